// File: hdl/periph_flags_pkg.sv
`default_nettype none
package periph_flags_pkg;

	// Bus widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFS_FLAGS_ONE = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAGS_TWO = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_POWER_CTRL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RESET_CAUSE = 8'h0C;

	// First flag register bit positions
	localparam int unsigned BIT_CONV_DONE = 6;
	localparam int unsigned BIT_SERIAL_RX = 5;
	localparam int unsigned BIT_SERIAL_TX = 4;
	localparam int unsigned BIT_SYNC_PORT = 3;
	localparam int unsigned BIT_CAPCMP_A = 2;
	localparam int unsigned BIT_PERIOD_MATCH = 1;
	localparam int unsigned BIT_WIDE_OVF = 0;
	localparam int unsigned BIT_ONE_SPARE = 7;

	// Second flag register bit positions
	localparam int unsigned BIT_OSC_FAIL = 7;
	localparam int unsigned BIT_COMPARATOR_B = 6;
	localparam int unsigned BIT_COMPARATOR_A = 5;
	localparam int unsigned BIT_NV_WRITE = 4;
	localparam int unsigned BIT_BUS_COLLISION = 3;
	localparam int unsigned BIT_LOWPOWER_WAKE = 2;
	localparam int unsigned BIT_CAPCMP_B = 0;
	localparam int unsigned BIT_TWO_SPARE = 1;

	// Power control bit positions
	localparam int unsigned BIT_ULP_WAKE_EN = 5;
	localparam int unsigned BIT_SW_BROWNOUT_EN = 4;
	localparam int unsigned BIT_POWER_ON_OK = 1;
	localparam int unsigned BIT_BROWN_OUT_OK = 0;

	// Reset cause bit positions
	localparam int unsigned BIT_WATCHDOG_SEEN = 0;
	localparam int unsigned BIT_MASTER_CLEAR_SEEN = 1;
	localparam int unsigned RESET_CAUSE_W = 2;

	// Software writable sticky flag bits
	localparam logic [REG_W-1:0] FLAGS_ONE_WR_MASK = 8'h4F;
	localparam logic [REG_W-1:0] FLAGS_TWO_WR_MASK = 8'hFD;

	// Reset values
	localparam logic [REG_W-1:0] FLAGS_RESET = 8'h00;
	localparam logic ULP_WAKE_EN_RESET = 1'b0;
	localparam logic SW_BROWNOUT_EN_RESET = 1'b1;
	localparam logic POWER_ON_OK_RESET = 1'b0;
	localparam logic BROWN_OUT_OK_RESET = 1'b0;

	// Capture/compare unit modes
	typedef enum logic [1:0] {
		CAPCMP_OFF,
		CAPCMP_CAPTURE,
		CAPCMP_COMPARE,
		CAPCMP_PWM
	} capcmp_mode_t;

	// Synchronous serial port modes
	typedef enum logic [1:0] {
		SYNC_OFF,
		SYNC_SPI,
		SYNC_I2C_SLAVE,
		SYNC_I2C_MASTER
	} sync_mode_t;

	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;

	// APB answer from the slave
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} apb_rsp_t;

endpackage
`default_nettype wire

// File: hdl/flag_cell.sv
`default_nettype none
module flag_cell
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Hardware event and software write
	input wire logic set_i,
	input wire logic wr_i,
	input wire logic wr_data_i,
	// Stored flag
	output logic flag_o
);

	// Sticky flag; an event in a write cycle still sets it
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			flag_o <= 1'b0;
		else
			flag_o <= set_i | (wr_i ? wr_data_i : flag_o);
	end

endmodule // flag_cell
`default_nettype wire

// File: hdl/change_detect.sv
`default_nettype none
module change_detect
#(
	parameter int unsigned WIDTH = 2
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Watched levels and change pulses
	input wire logic [WIDTH-1:0] level_i,
	output logic [WIDTH-1:0] changed_o
);

	logic [WIDTH-1:0] last_level;
	logic armed;

	// Remember the level; first cycle after reset only loads it
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			last_level <= '0;
			armed <= 1'b0;
		end
		else
		begin
			last_level <= level_i;
			armed <= 1'b1;
		end
	end

	// Any bit that differs from last cycle is a change
	assign changed_o = armed ? (level_i ^ last_level) : '0;

endmodule // change_detect
`default_nettype wire

// File: hdl/peripheral_interrupt_flags.sv
`default_nettype none
module peripheral_interrupt_flags
	import periph_flags_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire apb_req_t apb_req_i,
	output apb_rsp_t apb_rsp_o,
	// Converter
	input wire logic conv_done_i,
	// Asynchronous serial port
	input wire logic rx_buffer_full_i,
	input wire logic serial_rx_data_read_i,
	input wire logic tx_buffer_empty_i,
	input wire logic serial_tx_data_write_i,
	// Synchronous serial port
	input wire sync_mode_t sync_mode_i,
	input wire logic sync_xfer_done_i,
	input wire logic [3:0] master_seq_done_i,
	input wire logic sync_port_idle_i,
	input wire logic bus_start_seen_i,
	input wire logic bus_stop_seen_i,
	input wire logic bus_collision_i,
	// Capture/compare units
	input wire capcmp_mode_t capcmp_a_mode_i,
	input wire logic capcmp_a_capture_i,
	input wire logic capcmp_a_match_i,
	input wire capcmp_mode_t capcmp_b_mode_i,
	input wire logic capcmp_b_capture_i,
	input wire logic capcmp_b_match_i,
	// Timers
	input wire logic period_tick_i,
	input wire logic [7:0] period_count_i,
	input wire logic [7:0] period_value_i,
	input wire logic wide_timer_ovf_i,
	// Clock monitor, comparators, memory, wake-up
	input wire logic osc_failed_i,
	input wire logic on_internal_oscillator_i,
	input wire logic comparator_a_output_i,
	input wire logic comparator_b_output_i,
	input wire logic nv_write_done_i,
	input wire logic lowpower_wake_i,
	// Reset causes
	input wire logic brown_out_reset_i,
	input wire logic watchdog_reset_i,
	input wire logic external_master_clear_i,
	// Flags and enables to the core
	output logic [REG_W-1:0] peripheral_flags_one_o,
	output logic [REG_W-1:0] peripheral_flags_two_o,
	output logic ulp_wake_enable_o,
	output logic sw_brownout_enable_o
);

	// Bus phase decode
	wire setup_phase;
	wire access_phase;
	wire wr_strobe;
	wire hit_one;
	wire hit_two;
	wire hit_power;
	wire hit_cause;
	wire addr_hit;
	wire wr_one;
	wire wr_two;
	wire wr_power;
	wire wr_cause;
	wire [REG_W-1:0] wr_byte;

	// Event decode
	wire sync_is_i2c;
	wire sync_is_master;
	wire comparator_a_changed;
	wire comparator_b_changed;
	wire [1:0] comparator_changed;
	wire [REG_W-1:0] set_one;
	wire [REG_W-1:0] set_two;
	wire [2*REG_W-1:0] set_all;
	wire [2*REG_W-1:0] wr_all;
	// Writable positions of both flag registers, fixed at elaboration
	localparam logic [2*REG_W-1:0] WR_MASK_ALL =
		{FLAGS_TWO_WR_MASK, FLAGS_ONE_WR_MASK};
	wire [2*REG_W-1:0] sticky;
	wire [RESET_CAUSE_W-1:0] cause_set;
	wire [RESET_CAUSE_W-1:0] cause_q;

	// Level flags and power control state
	logic serial_rx_flag;
	logic serial_tx_flag;
	logic ulp_wake_en;
	logic sw_brownout_en;
	logic power_on_ok;
	logic brown_out_ok;
	logic [DATA_W-1:0] rd_data;
	wire [REG_W-1:0] flags_one_view;
	wire [REG_W-1:0] flags_two_view;
	wire [REG_W-1:0] power_view;
	wire [REG_W-1:0] cause_view;
	wire [REG_W-1:0] next_rd_byte;

	// APB phases; every access completes in its first access cycle
	assign setup_phase = apb_req_i.psel & ~apb_req_i.penable;
	assign access_phase = apb_req_i.psel & apb_req_i.penable;
	assign wr_strobe = access_phase & apb_req_i.pwrite & addr_hit;
	assign wr_byte = apb_req_i.pwdata[REG_W-1:0];

	// Address decode
	// An unmapped address matches none and stores nothing
	assign hit_one = (apb_req_i.paddr == OFS_FLAGS_ONE);
	assign hit_two = (apb_req_i.paddr == OFS_FLAGS_TWO);
	assign hit_power = (apb_req_i.paddr == OFS_POWER_CTRL);
	assign hit_cause = (apb_req_i.paddr == OFS_RESET_CAUSE);
	assign addr_hit = hit_one | hit_two | hit_power | hit_cause;

	// Write strobe per register
	assign wr_one = wr_strobe & hit_one;
	assign wr_two = wr_strobe & hit_two;
	assign wr_power = wr_strobe & hit_power;
	assign wr_cause = wr_strobe & hit_cause;

	// Synchronous port mode decode
	assign sync_is_i2c = (sync_mode_i == SYNC_I2C_SLAVE) |
		(sync_mode_i == SYNC_I2C_MASTER);
	assign sync_is_master = (sync_mode_i == SYNC_I2C_MASTER);

	// Comparator output change detection
	// Levels come from this clock domain, so no synchroniser is needed
	assign comparator_changed = {comparator_b_changed,
		comparator_a_changed};

	change_detect #(
		.WIDTH(2)
	) u_comparator_change (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.level_i({comparator_b_output_i, comparator_a_output_i}),
		.changed_o({comparator_b_changed, comparator_a_changed})
	);

	// Events of the first flag register; enables are never consulted
	// enables not consulted
	assign set_one[BIT_CONV_DONE] = conv_done_i;
	assign set_one[BIT_SYNC_PORT] =
		(sync_xfer_done_i & (sync_mode_i != SYNC_OFF)) |
		(sync_is_master & (|master_seq_done_i)) |
		(sync_is_i2c & sync_port_idle_i &
		(bus_start_seen_i | bus_stop_seen_i));
	assign set_one[BIT_CAPCMP_A] =
		((capcmp_a_mode_i == CAPCMP_CAPTURE) & capcmp_a_capture_i) |
		((capcmp_a_mode_i == CAPCMP_COMPARE) & capcmp_a_match_i);
	assign set_one[BIT_PERIOD_MATCH] = period_tick_i &
		(period_count_i == period_value_i);
	assign set_one[BIT_WIDE_OVF] = wide_timer_ovf_i;
	// Level bits and the unused bit carry no sticky event
	assign set_one[BIT_ONE_SPARE] = 1'b0;
	assign set_one[BIT_SERIAL_RX] = 1'b0;
	assign set_one[BIT_SERIAL_TX] = 1'b0;

	// Events of the second flag register
	// oscillator fail sets
	assign set_two[BIT_OSC_FAIL] = osc_failed_i & on_internal_oscillator_i;
	assign set_two[BIT_COMPARATOR_B] = comparator_changed[1];
	assign set_two[BIT_COMPARATOR_A] = comparator_changed[0];
	assign set_two[BIT_NV_WRITE] = nv_write_done_i;
	assign set_two[BIT_BUS_COLLISION] = bus_collision_i & sync_is_master;
	assign set_two[BIT_LOWPOWER_WAKE] = lowpower_wake_i;
	assign set_two[BIT_TWO_SPARE] = 1'b0;
	assign set_two[BIT_CAPCMP_B] =
		((capcmp_b_mode_i == CAPCMP_CAPTURE) & capcmp_b_capture_i) |
		((capcmp_b_mode_i == CAPCMP_COMPARE) & capcmp_b_match_i);

	// Combined view for the per-bit flag cells
	assign set_all = {set_two, set_one};
	assign wr_all = {{REG_W{wr_two}},
		{REG_W{wr_one}}};

	// One sticky cell per writable flag; other positions stay zero
	genvar gi;
	generate
		for (gi = 0; gi < 2 * REG_W; gi = gi + 1)
		begin : g_flag
			// Read-only and unused positions get no cell at all
			if (WR_MASK_ALL[gi])
			begin : g_cell
				flag_cell u_cell (
					.clock_i(clock_i),
					.sys_rst_i(sys_rst_i),
					.set_i(set_all[gi]),
					.wr_i(wr_all[gi]),
					.wr_data_i(wr_byte[gi % REG_W]),
					.flag_o(sticky[gi])
				);
			end
			else
			begin : g_none
				assign sticky[gi] = 1'b0;
			end
		end
	endgenerate

	// Reset causes that the power control bits do not cover
	assign cause_set[BIT_WATCHDOG_SEEN] = watchdog_reset_i;
	assign cause_set[BIT_MASTER_CLEAR_SEEN] = external_master_clear_i;

	generate
		for (gi = 0; gi < RESET_CAUSE_W; gi = gi + 1)
		begin : g_cause
			flag_cell u_cause (
				.clock_i(clock_i),
				.sys_rst_i(sys_rst_i),
				.set_i(cause_set[gi]),
				.wr_i(wr_cause),
				.wr_data_i(wr_byte[gi]),
				.flag_o(cause_q[gi])
			);
		end
	endgenerate

	// Serial flags mirror the buffers; the data access clears at once
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			serial_rx_flag <= 1'b0;
			serial_tx_flag <= 1'b0;
		end
		else
		begin
			// A buffer level still present afterwards sets it again
			// read clears receive
			serial_rx_flag <= rx_buffer_full_i & ~serial_rx_data_read_i;
			serial_tx_flag <= tx_buffer_empty_i & ~serial_tx_data_write_i;
		end
	end

	// Power control enables and reset status bits
	// status and enables
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			ulp_wake_en <= ULP_WAKE_EN_RESET;
			sw_brownout_en <= SW_BROWNOUT_EN_RESET;
			power_on_ok <= POWER_ON_OK_RESET;
			brown_out_ok <= BROWN_OUT_OK_RESET;
		end
		else
		begin
			// Software writes ones to the status bits once it has seen them
			if (wr_power)
			begin
				ulp_wake_en <= wr_byte[BIT_ULP_WAKE_EN];
				sw_brownout_en <= wr_byte[BIT_SW_BROWNOUT_EN];
				power_on_ok <= wr_byte[BIT_POWER_ON_OK];
			end
			// A brown-out marks itself over a software write
			if (brown_out_reset_i)
				brown_out_ok <= 1'b0;
			else if (wr_power)
				brown_out_ok <= wr_byte[BIT_BROWN_OUT_OK];
		end
	end

	// Read views; unused bits read as zero
	// access types merged
	assign flags_one_view = (sticky[REG_W-1:0] & FLAGS_ONE_WR_MASK) |
		({7'h00, serial_rx_flag} << BIT_SERIAL_RX) |
		({7'h00, serial_tx_flag} << BIT_SERIAL_TX);
	assign flags_two_view = sticky[2*REG_W-1:REG_W] & FLAGS_TWO_WR_MASK;
	assign power_view = ({7'h00, ulp_wake_en} << BIT_ULP_WAKE_EN) |
		({7'h00, sw_brownout_en} << BIT_SW_BROWNOUT_EN) |
		({7'h00, power_on_ok} << BIT_POWER_ON_OK) |
		({7'h00, brown_out_ok} << BIT_BROWN_OUT_OK);
	assign cause_view = {6'h00, cause_q};

	// Read data select
	assign next_rd_byte = hit_one ? flags_one_view :
		hit_two ? flags_two_view :
		hit_power ? power_view :
		hit_cause ? cause_view : 8'h00;

	// Read data is captured in the setup cycle
	// An event in the access cycle shows only in the next read
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
			rd_data <= 32'h0000_0000;
		else if (setup_phase)
			rd_data <= {24'h00_0000, next_rd_byte};
	end

	// APB answer
	// Zero wait states: ready in the first access cycle
	assign apb_rsp_o.pready = access_phase;
	assign apb_rsp_o.pslverr = access_phase & ~addr_hit;
	assign apb_rsp_o.prdata = rd_data;

	// Flag and enable outputs
	assign peripheral_flags_one_o = flags_one_view;
	assign peripheral_flags_two_o = flags_two_view;
	assign ulp_wake_enable_o = ulp_wake_en;
	assign sw_brownout_enable_o = sw_brownout_en;

endmodule // peripheral_interrupt_flags
`default_nettype wire

// File: sim/periph_flags_checker_assertions.sv
`default_nettype none
module periph_flags_checker
	import periph_flags_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Bus and event inputs
	input wire apb_req_t apb_req_i,
	input wire logic conv_done_i,
	input wire logic serial_rx_data_read_i,
	input wire logic serial_tx_data_write_i,
	input wire logic wide_timer_ovf_i,
	input wire logic comparator_a_output_i,
	// Flag views
	input wire logic [REG_W-1:0] peripheral_flags_one_o,
	input wire logic [REG_W-1:0] peripheral_flags_two_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// Short views and a completed write of the first flag register
	wire logic [7:0] f1 = peripheral_flags_one_o;
	wire logic [7:0] f2 = peripheral_flags_two_o;
	wire logic wr1 = apb_req_i.psel && apb_req_i.penable
		&& apb_req_i.pwrite && apb_req_i.paddr == OFS_FLAGS_ONE;
	sequence wr1_s;
		apb_req_i.psel && !apb_req_i.penable ##1 wr1;
	endsequence
	// Flag behaviour seen at the ports
	AST_CONV_SET: assert property (conv_done_i |=> f1[6])
		else $error("conversion flag not set");
	AST_CONV_HOLD: assert property (f1[6] && !wr1 |=> f1[6])
		else $error("conversion flag lost");
	AST_RX_CLR: assert property (serial_rx_data_read_i |=> !f1[5])
		else $error("receive flag kept after read");
	AST_TX_CLR: assert property (serial_tx_data_write_i |=> !f1[4])
		else $error("transmit flag kept after write");
	AST_OVF_SET: assert property (wide_timer_ovf_i |=> f1[0])
		else $error("overflow flag not set");
	AST_TOP_ZERO: assert property (!f1[7])
		else $error("flags one bit 7 set");
	AST_GAP_ZERO: assert property (!f2[1])
		else $error("flags two bit 1 set");
	AST_SET_WINS: assert property (wr1_s ##0 conv_done_i |=> f1[6])
		else $error("write beat the event");
	AST_CMP_A: assert property ($changed(comparator_a_output_i)
		&& !$past(sys_rst_i) && !$past(sys_rst_i, 2) |=> f2[5])
		else $error("comparator flag not set");
endmodule // periph_flags_checker
bind peripheral_interrupt_flags periph_flags_checker u_checker (
	.clock_i, .sys_rst_i, .apb_req_i, .conv_done_i, .serial_rx_data_read_i,
	.serial_tx_data_write_i, .wide_timer_ovf_i, .comparator_a_output_i,
	.peripheral_flags_one_o, .peripheral_flags_two_o);
`default_nettype wire

// File: sim/periph_model.sv
`default_nettype none
module periph_model
(
	// Clock
	input wire logic clock_i,
	// Event strobes and levels toward the flag block
	output logic [31:0] ev_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Peripherals start quiet
	initial ev_o = '0;
	// Drive now for one cycle, then after from the next edge on
	task automatic step(input logic [31:0] now, input logic [31:0] after);
		begin
			@(posedge clock_i);
			ev_o <= now;
			@(posedge clock_i);
			ev_o <= after;
		end
	endtask
endmodule // periph_model
`default_nettype wire

// File: sim/tb_top.sv
`default_nettype none
module tb_top
	import periph_flags_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Event pattern, register hit and expected byte
	typedef struct packed {
		logic [31:0] ev;
		logic [7:0] addr;
		logic [7:0] exp;
	} case_t;
	localparam case_t CASES [22] = '{
		'{32'h00000001, 8'h00, 8'h40},
		'{32'h00000020, 8'h00, 8'h08},
		'{32'h00010000, 8'h00, 8'h08}, '{32'h00020000, 8'h00, 8'h08},
		'{32'h00040000, 8'h00, 8'h08}, '{32'h00080000, 8'h00, 8'h08},
		'{32'h00100040, 8'h00, 8'h08}, '{32'h00100080, 8'h00, 8'h08},
		'{32'h00000200, 8'h00, 8'h04},
		'{32'h00000400, 8'h00, 8'h00}, // match ignored when capturing
		'{32'h00002000, 8'h00, 8'h02},
		'{32'h00004000, 8'h00, 8'h01},
		'{32'h00600000, 8'h04, 8'h80},
		'{32'h00800000, 8'h04, 8'h20}, '{32'h01000000, 8'h04, 8'h40},
		'{32'h00008000, 8'h04, 8'h10},
		'{32'h00000100, 8'h04, 8'h08},
		'{32'h02000000, 8'h04, 8'h04},
		'{32'h00001000, 8'h04, 8'h01},
		'{32'h00000800, 8'h04, 8'h00}, // capture ignored when comparing
		'{32'h08000000, 8'h0C, 8'h01}, '{32'h10000000, 8'h0C, 8'h02}
	};
	// Clock, reset, bus and peripheral wiring
	logic clock_i;
	logic sys_rst_i;
	apb_req_t req;
	apb_rsp_t rsp;
	logic [31:0] ev;
	capcmp_mode_t a_mode;
	capcmp_mode_t b_mode;
	sync_mode_t s_mode;
	logic [7:0] pcount;
	logic ulp_en;
	logic bo_en;
	logic [7:0] q;
	logic [7:0] flags_one;
	logic [7:0] flags_two;
	logic err;
	int mismatches;
	int tests_run;
	periph_model PER (.clock_i(clock_i), .ev_o(ev));
	peripheral_interrupt_flags DUT (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.apb_req_i(req), .apb_rsp_o(rsp),
		.conv_done_i(ev[0]), .rx_buffer_full_i(ev[1]),
		.serial_rx_data_read_i(ev[2]), .tx_buffer_empty_i(ev[3]),
		.serial_tx_data_write_i(ev[4]), .sync_mode_i(s_mode),
		.sync_xfer_done_i(ev[5]), .master_seq_done_i(ev[19:16]),
		.sync_port_idle_i(ev[20]), .bus_start_seen_i(ev[6]),
		.bus_stop_seen_i(ev[7]), .bus_collision_i(ev[8]),
		.capcmp_a_mode_i(a_mode), .capcmp_a_capture_i(ev[9]),
		.capcmp_a_match_i(ev[10]), .capcmp_b_mode_i(b_mode),
		.capcmp_b_capture_i(ev[11]), .capcmp_b_match_i(ev[12]),
		.period_tick_i(ev[13]), .period_count_i(pcount),
		.period_value_i(8'h5A), .wide_timer_ovf_i(ev[14]),
		.osc_failed_i(ev[21]), .on_internal_oscillator_i(ev[22]),
		.comparator_a_output_i(ev[23]), .comparator_b_output_i(ev[24]),
		.nv_write_done_i(ev[15]), .lowpower_wake_i(ev[25]),
		.brown_out_reset_i(ev[26]), .watchdog_reset_i(ev[27]),
		.external_master_clear_i(ev[28]),
		.peripheral_flags_one_o(flags_one),
		.peripheral_flags_two_o(flags_two),
		.ulp_wake_enable_o(ulp_en), .sw_brownout_enable_o(bo_en)
	);
	// One APB transfer; q and err take the answer
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [7:0] d);
		begin
			req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
			@(posedge clock_i);
			req.penable <= 1'b1;
			@(posedge clock_i);
			// Wait for the answer; only the hang guard ends a stuck wait
			while (rsp.pready !== 1'b1)
				@(posedge clock_i);
			q = rsp.prdata[7:0];
			err = rsp.pslverr;
			req <= '0;
			@(posedge clock_i);
		end
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		begin
			tests_run++;
			if (got !== exp)
			begin
				mismatches++;
				$display("wrong value %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		begin
			xfer(a, 1'b0, 8'h00);
			chk(q, exp);
		end
	endtask
	task automatic print_verdict;
		begin
			if (mismatches == 0 && tests_run > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// Clock at 4 ns
	initial
	begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	// Hang guard
	initial
	begin
		#20000;
		mismatches++;
		print_verdict();
	end
	// Main sequence
	initial
	begin
		sys_rst_i = 1'b1;
		req = '0;
		a_mode = CAPCMP_CAPTURE;
		b_mode = CAPCMP_COMPARE;
		s_mode = SYNC_I2C_MASTER;
		pcount = 8'h5A;
		mismatches = 0;
		tests_run = 0;
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h08, 8'h10);
		rd(8'h0C, 8'h00);
		xfer(8'h10, 1'b0, 8'h00);
		chk({7'h00, err}, 8'h01);
		xfer(8'h00, 1'b1, 8'hFF);
		rd(8'h00, 8'h4F);
		xfer(8'h04, 1'b1, 8'hFF);
		rd(8'h04, 8'hFD);
		xfer(8'h00, 1'b1, 8'h00);
		xfer(8'h04, 1'b1, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		// Buffer levels survive a write, strobes clear them
		PER.step(32'h0000000A, 32'h0000000A);
		xfer(8'h00, 1'b1, 8'h00);
		rd(8'h00, 8'h30);
		PER.step(32'h0000001E, 32'h00000000);
		rd(8'h00, 8'h00);
		// Each event sets its own flag only, with the enables at their reset values
		foreach (CASES[i])
		begin
			PER.step(CASES[i].ev, 32'h00000000);
			rd(CASES[i].addr, CASES[i].exp);
			if (CASES[i].addr != OFS_RESET_CAUSE)
				chk(CASES[i].addr[2] ? flags_two : flags_one, CASES[i].exp);
			xfer(CASES[i].addr, 1'b1, 8'h00);
		end
		// Units in waveform mode raise nothing
		a_mode <= CAPCMP_PWM;
		b_mode <= CAPCMP_PWM;
		PER.step(32'h00001E00, 32'h00000000);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		// Clearing write and event in the same cycle
		fork
			xfer(8'h00, 1'b1, 8'h00);
			PER.step(32'h00000001, 32'h00000000);
		join
		rd(8'h00, 8'h40);
		xfer(8'h08, 1'b1, 8'h33);
		rd(8'h08, 8'h33);
		chk({6'h00, ulp_en, bo_en}, 8'h03);
		PER.step(32'h04000000, 32'h00000000);
		rd(8'h08, 8'h32);
		// Port events count only in the modes that own them
		xfer(8'h00, 1'b1, 8'h00);
		s_mode <= SYNC_OFF;
		pcount <= 8'h59;
		PER.step(32'h00112160, 32'h00000000);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		s_mode <= SYNC_SPI;
		PER.step(32'h00112160, 32'h00000000);
		rd(8'h00, 8'h08);
		rd(8'h04, 8'h00);
		xfer(8'h00, 1'b1, 8'h00);
		s_mode <= SYNC_I2C_SLAVE;
		PER.step(32'h00010100, 32'h00000000);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		PER.step(32'h00100040, 32'h00000000);
		rd(8'h00, 8'h08);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
